// *** wcpp_pkg.sv ***
package wcpp_pkg;
  // lane widths
  localparam int TX_W   = 22;   // wide transmit word per channel
  localparam int RX_W   = 32;   // wide receive word per channel
  localparam int NR_W   = 16;   // narrow data per channel
  localparam int LANE_W = 16;   // one byte lane inside the receive word
  localparam int BYTE_W = 8;
  // flag positions inside a byte lane
  localparam int P_CTRL = 8;
  localparam int P_ERR  = 9;
  localparam int P_SYNC = 10;
  localparam int P_DISP = 11;
  localparam int P_PATT = 12;
  localparam int P_DEL  = 13;
  localparam int P_INS  = 14;
  localparam int P_RDSP = 15;
  // timing
  localparam int OC_CYC  = 16;  // offset cancel length in reconfig ticks
  localparam int RM_HOLD = 2;   // rate match flag cycles per ordered set
  localparam int OC_DIV  = 4;   // hclk cycles per reconfig tick
  // register map
  localparam logic [3:0] A_CTRL = 4'h0;
  localparam logic [3:0] A_STAT = 4'h4;
  localparam logic [3:0] A_MASK = 4'h8;
  localparam logic [3:0] A_OCST = 4'hC;
  // control fields
  localparam int C_WIDE = 0;
  localparam int C_RX   = 1;
  localparam int C_TX   = 2;
  localparam int C_PIPE = 3;
  localparam int C_W16  = 4;
  localparam int C_DEC  = 5;
  localparam int C_WA   = 6;
  localparam int C_RM   = 7;
  localparam int C_OCGO = 8;
  localparam logic [7:0] CTRL_RST = 8'hF7;
  // status fields
  localparam int S_DEL = 0;
  localparam int S_INS = 1;
  localparam int S_OCD = 2;
  localparam int S_PDV = 3;
  localparam int NIRQ  = 4;
  localparam logic [3:0] MASK_RST = 4'h0;
  localparam logic       RESP_OKAY = 1'b0;
  // offset cancel sequencer
  typedef enum logic [1:0] {
    OC_IDLE = 2'b00,
    OC_RUN  = 2'b01,
    OC_DONE = 2'b10
  } wcpp_oc_st_t;
endpackage : wcpp_pkg

// *** wcpp_lane_if.sv ***
`timescale 1ns/1ps
interface wcpp_lane_if #(parameter int NL = 2);
  logic [NL*8-1:0]  data;   // decoded bytes, lane order
  logic [NL-1:0]    ctrl;   // control character seen
  logic [NL-1:0]    err;    // code error
  logic [NL-1:0]    sync;   // aligner in sync
  logic [NL-1:0]    disp;   // disparity error
  logic [NL-1:0]    patt;   // alignment pattern seen
  logic [NL-1:0]    del;    // stretched deletion flag
  logic [NL-1:0]    ins;    // stretched insertion flag
  logic [NL*2-1:0]  pst;    // pipe status, two bits a lane
  logic [NL-1:0]    rdsp;   // running disparity
  logic             pipe;   // pipe functional mode
  logic             w16;    // 16-bit fabric width
  logic             dec;    // 8b10b decoder enabled
  logic [NL*16-1:0] word;   // packed lanes
  modport src (output data, ctrl, err, sync, disp, patt, del, ins, pst, rdsp,
               output pipe, w16, dec, input word);
  modport pk  (input data, ctrl, err, sync, disp, patt, del, ins, pst, rdsp,
               input pipe, w16, dec, output word);
endinterface : wcpp_lane_if

// *** wcpp_lane_pack.sv ***
`timescale 1ns/1ps
module wcpp_lane_pack #(
  parameter int NL = 2
) (
  wcpp_lane_if.pk lp  // lane fields in, packed word out
);
  // each byte lane fills 16 bits; odd lanes are the high byte of a channel
  for (genvar i = 0; i < NL; i++) begin : g_lane
    localparam int  B  = i * wcpp_pkg::LANE_W;
    localparam bit  HI = (i % 2) == 1;
    logic keep;
    logic dk;
    assign keep = !HI || lp.w16;  // R17
    assign dk   = keep && lp.dec;
    assign lp.word[B+7:B] = keep ? lp.data[i*8+7:i*8] : 8'h00;  // R5
    assign lp.word[B+wcpp_pkg::P_CTRL] = dk && lp.ctrl[i];  // R6
    assign lp.word[B+wcpp_pkg::P_ERR]  = dk && lp.err[i];  // R7
    assign lp.word[B+wcpp_pkg::P_SYNC] = keep && lp.sync[i];  // R8
    assign lp.word[B+wcpp_pkg::P_DISP] = dk && lp.disp[i];  // R9
    assign lp.word[B+wcpp_pkg::P_PATT] = keep && lp.patt[i];  // R10
    // rate match flags, or pipe status in pipe mode
    assign lp.word[B+wcpp_pkg::P_INS:B+wcpp_pkg::P_DEL] =
      !keep   ? 2'h0 :
      lp.pipe ? lp.pst[i*2+1:i*2] :  // R13
                {lp.ins[i], lp.del[i]};  // R11 R12
    assign lp.word[B+wcpp_pkg::P_RDSP] = dk && lp.rdsp[i];  // R14
  end
endmodule : wcpp_lane_pack

// *** wcpp_top.sv ***
`timescale 1ns/1ps
// Operation
// R1: wide transmit input is 22 bits per channel.
// R2: wide receive output is 32 bits per channel.
// R3: wide transmit input replaces narrow one in transmit configurations only.
// R4: wide receive output replaces narrow one in receive configurations.
// R5: low byte on bits 7:0, high byte on bits 23:16.
// R6: control flags on bits 8 and 24.
// R7: code error flags on bits 9 and 25.
// R8: sync flags on bits 10 and 26.
// R9: disparity error flags on bits 11 and 27.
// R10: pattern detect flags on bits 12 and 28.
// R11: outside pipe mode, deletion flags on bits 13 and 29.
// R12: outside pipe mode, insertion flags on bits 14 and 30.
// R13: in pipe mode, pipe status on bits 14:13 and 30:29.
// R14: running disparity on bits 15 and 31.
// R15: offset cancellation model lasts 16 reconfig clock ticks.
// R16: other party keeps powerdown low during offset cancellation.
// R17: width, status set and pcs block enables are reconfigurable.
// R18: rate match flags hold two cycles per ordered set.
// R19: channels concatenate in order, channel zero lowest.
module wcpp_top #(
  parameter int NCH    = 1,
  parameter int OC_DIV = wcpp_pkg::OC_DIV
) (
  input  wire logic                             hclk,            // bus clock
  input  wire logic                             hresetn,         // async reset
  input  wire logic                             hsel,            // slave select
  input  wire logic [31:0]                      haddr,           // address
  input  wire logic [1:0]                       htrans,          // transfer type
  input  wire logic                             hwrite,          // write
  input  wire logic [2:0]                       hsize,           // size, word only
  input  wire logic [31:0]                      hwdata,          // write data
  input  wire logic                             hready,          // bus ready
  output logic                                  hreadyout,       // slave ready
  output logic [31:0]                           hrdata,          // read data
  output logic                                  hresp,           // response
  output logic                                  irq,             // interrupt
  input  wire logic [NCH*wcpp_pkg::TX_W-1:0]    tx_wide,         // fabric tx word
  input  wire logic [NCH*wcpp_pkg::NR_W-1:0]    tx_narrow,       // fabric tx data
  output logic [NCH*wcpp_pkg::TX_W-1:0]         xcvr_tx,         // to channel
  input  wire logic [NCH*wcpp_pkg::NR_W-1:0]    rx_data,         // decoded bytes
  input  wire logic [NCH*2-1:0]                 rx_ctrl,         // control char
  input  wire logic [NCH*2-1:0]                 rx_err,          // code error
  input  wire logic [NCH*2-1:0]                 rx_sync,         // in sync
  input  wire logic [NCH*2-1:0]                 rx_disp,         // disparity err
  input  wire logic [NCH*2-1:0]                 rx_patt,         // pattern seen
  input  wire logic [NCH*2-1:0]                 rx_rmdel,        // deletion pulse
  input  wire logic [NCH*2-1:0]                 rx_rmins,        // insertion pulse
  input  wire logic [NCH*4-1:0]                 rx_pipest,       // pipe status
  input  wire logic [NCH*2-1:0]                 rx_rdisp,        // running disp
  output logic [NCH*wcpp_pkg::RX_W-1:0]         rx_wide,         // fabric rx word
  output logic [NCH*wcpp_pkg::NR_W-1:0]         rx_narrow,       // fabric rx data
  input  wire logic                             xcvr_powerdown,  // channel power down
  output logic [4:0]                            pcs_cfg,         // rm wa dec w16 pipe
  output logic                                  oc_busy          // offset cancel active
);
  localparam int NL = 2 * NCH;

  logic [7:0]                  ctrl_q;
  logic [wcpp_pkg::NIRQ-1:0]   stat_q;
  logic [wcpp_pkg::NIRQ-1:0]   mask_q;
  logic [wcpp_pkg::NIRQ-1:0]   ev;
  logic [wcpp_pkg::NIRQ-1:0]   clr;
  logic                        wr_q;
  logic                        rd_q;
  logic [3:0]                  adr_q;
  logic                        ap;
  logic                        wr_fire;
  logic                        oc_go;
  logic [31:0]                 rmux;
  wcpp_pkg::wcpp_oc_st_t       st_q;
  logic [7:0]                  dv_q;
  logic [4:0]                  oc_cnt_q;
  logic                        tick;
  logic                        wide_on;
  logic                        rx_en;
  logic                        tx_en;

  wcpp_lane_if #(.NL(NL)) lp ();

  wcpp_lane_pack #(.NL(NL)) u_pack (
    .lp (lp.pk)
  );

  // bus address phase decode
  assign ap      = hsel && hready && htrans[1];
  assign wr_fire = wr_q && hready;
  assign oc_go   = wr_fire && adr_q == wcpp_pkg::A_CTRL && hwdata[wcpp_pkg::C_OCGO];
  assign wide_on = ctrl_q[wcpp_pkg::C_WIDE];
  assign rx_en   = ctrl_q[wcpp_pkg::C_RX];
  assign tx_en   = ctrl_q[wcpp_pkg::C_TX];

  // address phase capture
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q  <= 1'b0;
      rd_q  <= 1'b0;
      adr_q <= 4'h0;
    end else if (hready) begin
      wr_q  <= ap && hwrite;
      rd_q  <= ap && !hwrite;
      adr_q <= haddr[3:0];
    end
  end

  // reads take one wait state so hrdata comes from a flop
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hrdata    <= 32'h0000_0000;
      hresp     <= wcpp_pkg::RESP_OKAY;
    end else begin
      hreadyout <= !(ap && !hwrite);
      hresp     <= wcpp_pkg::RESP_OKAY;
      if (rd_q && !hreadyout) begin
        hrdata <= rmux;
      end
    end
  end

  // read mux, unmapped reads zero
  always_comb begin
    case (adr_q)
      wcpp_pkg::A_CTRL: rmux = {24'h00_0000, ctrl_q};
      wcpp_pkg::A_STAT: rmux = {28'h000_0000, stat_q};
      wcpp_pkg::A_MASK: rmux = {28'h000_0000, mask_q};
      wcpp_pkg::A_OCST: rmux = {26'h000_0000, oc_cnt_q, oc_busy};
      default:          rmux = 32'h0000_0000;
    endcase
  end

  // control and mask registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_q <= wcpp_pkg::CTRL_RST;
      mask_q <= wcpp_pkg::MASK_RST;
    end else if (wr_fire) begin
      if (adr_q == wcpp_pkg::A_CTRL) ctrl_q <= hwdata[7:0];  // R17
      if (adr_q == wcpp_pkg::A_MASK) mask_q <= hwdata[wcpp_pkg::NIRQ-1:0];
    end
  end

  // sticky status, a new event wins over a clear
  assign clr = (wr_fire && adr_q == wcpp_pkg::A_STAT) ? hwdata[wcpp_pkg::NIRQ-1:0] : 4'h0;
  assign ev[wcpp_pkg::S_DEL] = ctrl_q[wcpp_pkg::C_RM] && (|rx_rmdel);
  assign ev[wcpp_pkg::S_INS] = ctrl_q[wcpp_pkg::C_RM] && (|rx_rmins);
  assign ev[wcpp_pkg::S_OCD] = st_q == wcpp_pkg::OC_DONE;
  assign ev[wcpp_pkg::S_PDV] = st_q == wcpp_pkg::OC_RUN && xcvr_powerdown;  // R16

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stat_q <= 4'h0;
      irq    <= 1'b0;
    end else begin
      stat_q <= (stat_q & ~clr) | ev;
      irq    <= |(stat_q & mask_q);
    end
  end

  // reconfig tick divider, runs only during cancellation
  assign tick = st_q == wcpp_pkg::OC_RUN && dv_q == 8'(OC_DIV - 1);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dv_q <= 8'h00;
    end else if (st_q != wcpp_pkg::OC_RUN || tick) begin
      dv_q <= 8'h00;
    end else begin
      dv_q <= dv_q + 8'h01;
    end
  end

  // offset cancellation sequencer
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_q     <= wcpp_pkg::OC_IDLE;
      oc_cnt_q <= 5'h00;
      oc_busy  <= 1'b0;
    end else begin
      case (st_q)
        wcpp_pkg::OC_IDLE: begin
          if (oc_go) begin
            st_q     <= wcpp_pkg::OC_RUN;
            oc_cnt_q <= 5'h00;
            oc_busy  <= 1'b1;
          end
        end
        wcpp_pkg::OC_RUN: begin
          if (tick) begin
            oc_cnt_q <= oc_cnt_q + 5'h01;
            if (oc_cnt_q == 5'(wcpp_pkg::OC_CYC - 1)) begin  // R15
              st_q    <= wcpp_pkg::OC_DONE;
              oc_busy <= 1'b0;
            end
          end
        end
        wcpp_pkg::OC_DONE: st_q <= wcpp_pkg::OC_IDLE;
        default:           st_q <= wcpp_pkg::OC_IDLE;
      endcase
    end
  end

  // rate match flags stretched per ordered set
  for (genvar i = 0; i < NL; i++) begin : g_rm
    logic [2:0] dc_q;
    logic [2:0] ic_q;
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        dc_q <= 3'h0;
        ic_q <= 3'h0;
      end else begin
        dc_q <= hold_next(dc_q, rx_rmdel[i] && ctrl_q[wcpp_pkg::C_RM]);  // R18
        ic_q <= hold_next(ic_q, rx_rmins[i] && ctrl_q[wcpp_pkg::C_RM]);  // R18
      end
    end
    assign lp.del[i] = dc_q != 3'h0;
    assign lp.ins[i] = ic_q != 3'h0;
  end

  function automatic logic [2:0] hold_next(input logic [2:0] c, input logic e);
    logic [3:0] s;
    s = {1'b0, c} - {3'h0, c != 3'h0} + (e ? 4'(wcpp_pkg::RM_HOLD) : 4'h0);
    return (s > 4'h7) ? 3'h7 : s[2:0];
  endfunction : hold_next

  // lane fields into the packer
  assign lp.data = rx_data;
  assign lp.ctrl = rx_ctrl;
  assign lp.err  = rx_err;
  assign lp.sync = rx_sync;
  assign lp.disp = rx_disp;
  assign lp.patt = rx_patt;
  assign lp.pst  = rx_pipest;
  assign lp.rdsp = rx_rdisp;
  assign lp.pipe = ctrl_q[wcpp_pkg::C_PIPE];
  assign lp.w16  = ctrl_q[wcpp_pkg::C_W16];
  assign lp.dec  = ctrl_q[wcpp_pkg::C_DEC];

  // receive outputs, wide word replaces narrow data
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_wide   <= '0;
      rx_narrow <= '0;
      pcs_cfg   <= 5'h00;
    end else begin
      rx_wide   <= (wide_on && rx_en) ? lp.word : '0;  // R2 R4 R19
      rx_narrow <= (!wide_on && rx_en) ? rx_data : '0;  // R4
      pcs_cfg   <= {ctrl_q[wcpp_pkg::C_RM], ctrl_q[wcpp_pkg::C_WA], ctrl_q[wcpp_pkg::C_DEC],
                    ctrl_q[wcpp_pkg::C_W16], ctrl_q[wcpp_pkg::C_PIPE]};  // R17
    end
  end

  // transmit select per channel, channel zero lowest
  for (genvar c = 0; c < NCH; c++) begin : g_tx
    localparam int TB = c * wcpp_pkg::TX_W;
    localparam int NB = c * wcpp_pkg::NR_W;
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        xcvr_tx[TB+wcpp_pkg::TX_W-1:TB] <= '0;
      end else if (!tx_en) begin
        xcvr_tx[TB+wcpp_pkg::TX_W-1:TB] <= '0;  // R3
      end else if (wide_on) begin
        xcvr_tx[TB+wcpp_pkg::TX_W-1:TB] <= tx_wide[TB+wcpp_pkg::TX_W-1:TB];  // R1 R3 R19
      end else begin
        xcvr_tx[TB+wcpp_pkg::TX_W-1:TB] <= {6'h00, tx_narrow[NB+wcpp_pkg::NR_W-1:NB]};
      end
    end
  end

  // checks on channel zero
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic rxw;
  assign rxw = wide_on && rx_en && ctrl_q[wcpp_pkg::C_W16] && ctrl_q[wcpp_pkg::C_DEC];

  // one isolated rate match pulse on lane 0
  sequence s_del_pulse;
    rx_rmdel[0] && ctrl_q[wcpp_pkg::C_RM] && !lp.del[0];
  endsequence
  sequence s_ins_pulse;
    rx_rmins[0] && ctrl_q[wcpp_pkg::C_RM] && !lp.ins[0];
  endsequence
  sequence s_oc_start;
    st_q == wcpp_pkg::OC_IDLE && oc_go;
  endsequence

  chk_byte_place: assert property (rxw |=> rx_wide[7:0] == $past(rx_data[7:0])  // R5
    && rx_wide[23:16] == $past(rx_data[15:8])) else $error("byte placement wrong");
  chk_ctrl_flag: assert property (rxw |=> rx_wide[8] == $past(rx_ctrl[0])  // R6
    && rx_wide[24] == $past(rx_ctrl[1])) else $error("control flag misplaced");
  chk_err_flag: assert property (rxw |=> rx_wide[25:24] == $past({rx_err[1], rx_ctrl[1]})  // R7
    && rx_wide[9] == $past(rx_err[0])) else $error("error flag misplaced");
  chk_sync_disp: assert property (rxw |=> {rx_wide[27:26], rx_wide[11:10]}  // R8
    == $past({rx_disp[1], rx_sync[1], rx_disp[0], rx_sync[0]})) else $error("sync or disp");
  chk_patt_flag: assert property (rxw |=> {rx_wide[28], rx_wide[12]}  // R10
    == $past(rx_patt[1:0])) else $error("pattern flag misplaced");
  chk_rm_flags: assert property (rxw && !lp.pipe |=> {rx_wide[30:29], rx_wide[14:13]}  // R11
    == $past({lp.ins[1], lp.del[1], lp.ins[0], lp.del[0]})) else $error("rate match bits");
  chk_pipe_stat: assert property (rxw && lp.pipe |=> {rx_wide[30:29], rx_wide[14:13]}  // R13
    == $past(rx_pipest[3:0])) else $error("pipe status misplaced");
  chk_rdisp_bit: assert property (rxw |=> {rx_wide[31], rx_wide[15]}  // R14
    == $past(rx_rdisp[1:0])) else $error("running disparity misplaced");
  chk_rm_hold: assert property (s_del_pulse ##1 !rx_rmdel[0] [*2]  // R18
    |-> $past(lp.del[0]) && lp.del[0] ##1 !lp.del[0]) else $error("deletion hold not two");
  chk_oc_length: assert property (s_oc_start |=> oc_busy [*8] ##0  // R15
    (ev[wcpp_pkg::S_OCD] == 1'b0)) else $error("offset cancel ended early");
  chk_oc_done: assert property ($fell(oc_busy) |-> oc_cnt_q == 5'(wcpp_pkg::OC_CYC)  // R15
    && dv_q == 8'h00) else $error("offset cancel tick count wrong");
  chk_tx_select: assert property (tx_en && wide_on |=> xcvr_tx[wcpp_pkg::TX_W-1:0]  // R3
    == $past(tx_wide[wcpp_pkg::TX_W-1:0])) else $error("wide tx not selected");
  chk_rx_narrow: assert property (wide_on |=> rx_narrow == '0)  // R4
    else $error("narrow rx active with wide word");

  // receive and transmit selection
  chk_narrow_rx: assert property (!wide_on && rx_en |=> rx_narrow == $past(rx_data))  // R4
    else $error("narrow rx data wrong");
  chk_rx_off: assert property (!rx_en |=> rx_wide == '0 && rx_narrow == '0)  // R4
    else $error("rx word active while receive off");
  chk_tx_off: assert property (!tx_en |=> xcvr_tx == '0)  // R3
    else $error("tx word active while transmit off");

  // more lane layout and rate match hold
  chk_disp_flag: assert property (rxw |=> {rx_wide[27], rx_wide[11]}  // R9
    == $past(rx_disp[1:0])) else $error("disparity flag misplaced");
  chk_ins_bits: assert property (rxw && !lp.pipe |=> {rx_wide[30], rx_wide[14]}  // R12
    == $past(lp.ins[1:0])) else $error("insertion flag misplaced");
  chk_ins_hold: assert property (s_ins_pulse ##1 !rx_rmins[0] [*2]  // R18
    |-> $past(lp.ins[0]) && lp.ins[0] ##1 !lp.ins[0]) else $error("insertion hold not two");

  // bus wait state, interrupt and sticky status
  chk_read_wait: assert property (ap && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait state not one cycle");
  chk_irq_level: assert property (irq == $past(|(stat_q & mask_q)))
    else $error("interrupt level wrong");
  chk_stat_set: assert property (|ev |=> (stat_q & $past(ev)) == $past(ev))
    else $error("status event lost");
  chk_clr_w1c: assert property (wr_fire && adr_q == wcpp_pkg::A_STAT && hwdata[wcpp_pkg::S_OCD]
    && !ev[wcpp_pkg::S_OCD] |=> !stat_q[wcpp_pkg::S_OCD]) else $error("status clear ignored");
endmodule : wcpp_top

// *** wcpp_fabric_model.sv ***
`timescale 1ns/1ps
module wcpp_fabric_model #(
  parameter int NCH = 2
) (
  input  wire logic               hclk,       // channel clock
  input  wire logic               hresetn,    // async reset
  input  wire logic [NCH*32-1:0]  rx_word,    // packed receive words
  input  wire logic               pd_req,     // scenario asks for power down
  output logic                    powerdown,  // channel power down
  output logic [7:0]              del_cnt_q   // cycles lane 0 reported a deletion
);
  // power down stays low unless a scenario commands the misuse
  assign powerdown = pd_req;
  // fabric side counts deletion flag cycles on lane 0
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      del_cnt_q <= 8'h00;
    end else if (rx_word[13]) begin
      del_cnt_q <= del_cnt_q + 8'h01;
    end
  end
endmodule : wcpp_fabric_model

// *** tb_wide_channel_port_packer.sv ***
`timescale 1ns/1ps
module tb_wide_channel_port_packer;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq, pd_req, pdn, oc_busy;
  logic [31:0] haddr, hwdata, hrdata, rd, tx_narrow, rx_data, rx_narrow;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [43:0] tx_wide, xcvr_tx;
  logic [3:0]  rx_ctrl, rx_err, rx_sync, rx_disp, rx_patt, rx_rmdel, rx_rmins, rx_rdisp;
  logic [7:0]  rx_pipest, del_cnt, n0;
  logic [63:0] rx_wide;
  logic [4:0]  pcs_cfg;
  int          miscompares, cmp_count, cyc, n;

  wcpp_top #(.NCH(2), .OC_DIV(1)) u_wcpp_top (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .irq(irq),
    .tx_wide(tx_wide), .tx_narrow(tx_narrow), .xcvr_tx(xcvr_tx), .rx_data(rx_data),
    .rx_ctrl(rx_ctrl), .rx_err(rx_err), .rx_sync(rx_sync), .rx_disp(rx_disp),
    .rx_patt(rx_patt), .rx_rmdel(rx_rmdel), .rx_rmins(rx_rmins), .rx_pipest(rx_pipest),
    .rx_rdisp(rx_rdisp), .rx_wide(rx_wide), .rx_narrow(rx_narrow),
    .xcvr_powerdown(pdn), .pcs_cfg(pcs_cfg), .oc_busy(oc_busy));

  wcpp_fabric_model #(.NCH(2)) u_wcpp_fabric_model (
    .hclk(hclk), .hresetn(hresetn), .rx_word(rx_wide), .pd_req(pd_req),
    .powerdown(pdn), .del_cnt_q(del_cnt));

  // 40 MHz clock
  initial begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end

  // hang guard
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 5000) begin
      miscompares++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : report_and_stop

  task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // one ahb-lite single word transfer, waits on hready
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] wd);
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= {28'h0, a};
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : bus

  // lane fields from pattern k, then two cycles for the registered path
  task automatic set_rx(input int k);
    logic [3:0] v;
    v = 4'h1 << k;
    @(posedge hclk);
    rx_data   <= 32'hC3A5_691E ^ {8{v}};
    rx_ctrl   <= v;
    rx_err    <= ~v;
    rx_sync   <= v ^ 4'h5;
    rx_disp   <= v ^ 4'hA;
    rx_patt   <= ~v ^ 4'h3;
    rx_rdisp  <= v ^ 4'hC;
    rx_pipest <= {v, v} ^ 8'h96;
    tx_wide   <= {11{v}};
    tx_narrow <= {8{v}} ^ 32'h1234_ABCD;
    @(posedge hclk);
    @(posedge hclk);
    #1;
  endtask : set_rx

  // expected packed word, lane l at bits 16l up
  function automatic logic [63:0] exp_rx(input logic pipe);
    logic [63:0] w;
    w = '0;
    for (int l = 0; l < 4; l++) begin
      w[16*l+:16] = {rx_rdisp[l], pipe & rx_pipest[2*l+1], pipe & rx_pipest[2*l],
                     rx_patt[l], rx_disp[l], rx_sync[l], rx_err[l], rx_ctrl[l],
                     rx_data[8*l+:8]};
    end
    return w;
  endfunction : exp_rx

  // main sequence
  initial begin
    hresetn = 1'b0; hsel = 1'b0; haddr = '0; htrans = 2'b00; hwrite = 1'b0;
    hsize = 3'b010; hwdata = '0; tx_wide = '0; tx_narrow = '0; rx_data = '0;
    rx_ctrl = '0; rx_err = '0; rx_sync = '0; rx_disp = '0; rx_patt = '0;
    rx_rmdel = '0; rx_rmins = '0; rx_pipest = '0; rx_rdisp = '0; pd_req = 1'b0;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    chk("tx width", $bits(u_wcpp_top.tx_wide), 2 * wcpp_pkg::TX_W);
    chk("rx width", $bits(u_wcpp_top.rx_wide), 2 * wcpp_pkg::RX_W);
    bus(1'b0, wcpp_pkg::A_CTRL, 32'h0);
    chk("ctrl reset", rd, 32'hF7);
    chk("pcs cfg reset", pcs_cfg, 5'b11110);
    // every field pattern through wide receive and transmit
    for (int k = 0; k < 4; k++) begin
      set_rx(k);
      chk("rx wide", rx_wide, exp_rx(1'b0));
      chk("tx wide", xcvr_tx, tx_wide);
    end
    // pipe mode swaps rate match flags for pipe status
    bus(1'b1, wcpp_pkg::A_CTRL, 32'hFF);
    set_rx(1);
    chk("pcs cfg pipe", pcs_cfg, 5'h1F);
    chk("rx wide pipe", rx_wide, exp_rx(1'b1));
    // narrow ports when wide mode is off
    bus(1'b1, wcpp_pkg::A_CTRL, 32'hF6);
    set_rx(2);
    chk("rx wide off", rx_wide, 64'h0);
    chk("rx narrow", rx_narrow, rx_data);
    chk("tx narrow", xcvr_tx, {6'h0, tx_narrow[31:16], 6'h0, tx_narrow[15:0]});
    // receive only, then transmit only
    bus(1'b1, wcpp_pkg::A_CTRL, 32'hF3);
    set_rx(3);
    chk("tx off", xcvr_tx, 44'h0);
    chk("rx only", rx_wide, exp_rx(1'b0));
    bus(1'b1, wcpp_pkg::A_CTRL, 32'hF5);
    set_rx(0);
    chk("rx off", rx_wide, 64'h0);
    chk("tx only", xcvr_tx, tx_wide);
    // deletion and insertion pulses give two flag cycles each and a masked interrupt
    bus(1'b1, wcpp_pkg::A_CTRL, 32'hF7);
    bus(1'b1, wcpp_pkg::A_MASK, 32'h1);
    n0 = del_cnt;
    @(posedge hclk);
    rx_rmdel <= 4'h1;
    rx_rmins <= 4'h1;
    @(posedge hclk);
    rx_rmdel <= 4'h0;
    rx_rmins <= 4'h0;
    repeat (6) @(posedge hclk);
    chk("deletion cycles", del_cnt - n0, 8'h02);
    bus(1'b0, wcpp_pkg::A_STAT, 32'h0);
    chk("status del", rd[3:0], 4'h3);
    chk("irq del", irq, 1'b1);
    bus(1'b1, wcpp_pkg::A_STAT, 32'h3);
    repeat (3) @(posedge hclk);
    chk("irq cleared", irq, 1'b0);
    // offset cancellation length and done event
    bus(1'b1, wcpp_pkg::A_MASK, 32'h4);
    bus(1'b1, wcpp_pkg::A_CTRL, 32'h1F7);
    n = 0;
    repeat (40) begin
      @(posedge hclk);
      if (oc_busy === 1'b1) n++;
    end
    chk("cancel cycles", n, 16);
    chk("irq done", irq, 1'b1);
    bus(1'b0, wcpp_pkg::A_STAT, 32'h0);
    chk("status done", rd[3:0], 4'h4);
    bus(1'b1, wcpp_pkg::A_STAT, 32'h4);
    // power down raised in mid cancel is flagged
    bus(1'b1, wcpp_pkg::A_CTRL, 32'h1F7);
    @(posedge hclk);
    pd_req <= 1'b1;
    repeat (40) @(posedge hclk);
    pd_req <= 1'b0;
    bus(1'b0, wcpp_pkg::A_STAT, 32'h0);
    chk("status pd", rd[3:0], 4'hC);
    bus(1'b1, wcpp_pkg::A_STAT, 32'hF);
    bus(1'b0, wcpp_pkg::A_STAT, 32'h0);
    chk("status clear", rd, 32'h0);
    chk("resp", hresp, wcpp_pkg::RESP_OKAY);
    report_and_stop();
  end
endmodule : tb_wide_channel_port_packer
